// File: hdl/rtc_cal_params.svh
// Constants for the calendar counting chain: offsets, fields, resets and timing
`ifndef RTC_CAL_PARAMS_SVH
`define RTC_CAL_PARAMS_SVH

// ----------------------------------------------------------------
// Register indices on the 8-bit register port
// ----------------------------------------------------------------
`define CAL_NUM_CNT 6
`define CAL_IDX_SEC 3'h0
`define CAL_IDX_MIN 3'h1
`define CAL_IDX_HOUR 3'h2
`define CAL_IDX_DAY 3'h3
`define CAL_IDX_WEEK 3'h4
`define CAL_IDX_MONTH 3'h5
`define CAL_IDX_CTRL0 3'h6

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define CAL_CTRL0_HSEL_BIT 3
`define CAL_HOUR_PM_BIT 5

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define CAL_RST_SEC 8'h00
`define CAL_RST_MIN 8'h00
`define CAL_RST_HOUR 8'h12
`define CAL_RST_DAY 8'h01
`define CAL_RST_WEEK 8'h00
`define CAL_RST_MONTH 8'h01
`define CAL_RST_HSEL 1'b0

// ----------------------------------------------------------------
// Counter limits, binary
// ----------------------------------------------------------------
`define CAL_SEC_MAX 8'd59
`define CAL_MIN_MAX 8'd59
`define CAL_HOUR24_MAX 8'd23
`define CAL_WEEK_MAX 8'd6
`define CAL_MONTH_MAX 8'd12
`define CAL_DAY_MIN 8'd1
`define CAL_MONTH_MIN 8'd1

// ----------------------------------------------------------------
// Timing: calendar count clock derived from the system clock
// ----------------------------------------------------------------
`define CAL_CLK_HZ 125000000
`define CAL_FRTC_HZ 32768
`define CAL_CE_DIV (`CAL_CLK_HZ / `CAL_FRTC_HZ)

`endif

// File: hdl/rtc_cal_pkg.sv
// Types shared by the calendar counting chain modules
package rtc_cal_pkg;
	typedef logic [7:0] bcd_t;
	typedef logic [2:0] cal_idx_t;
	typedef logic [5:0][7:0] cal_bank_t;
	typedef logic [5:0] cal_flags_t;
endpackage

// File: hdl/cal_wbuf_if.sv
// Carrier between the counting chain and its write holding buffer
`timescale 1ns/1ps
interface cal_wbuf_if;
	import rtc_cal_pkg::*;
	logic wr;
	cal_idx_t idx;
	bcd_t wdata;
	logic xfer;
	cal_flags_t pend;
	cal_bank_t data;

	modport chain (output wr, output idx, output wdata, output xfer, input pend, input data);
	modport store (input wr, input idx, input wdata, input xfer, output pend, output data);
endinterface

// File: hdl/cal_write_buffer.sv
// Holding buffer for software writes to the calendar count registers
`timescale 1ns/1ps
`include "rtc_cal_params.svh"
module cal_write_buffer
	import rtc_cal_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_rst,
	cal_wbuf_if.store bus
);
	// ----------------------------------------------------------------
	// Per-register byte and pending flag
	// ----------------------------------------------------------------
	genvar g;
	generate
		for (g = 0; g < `CAL_NUM_CNT; g++) begin : g_slot
			logic hit;
			assign hit = bus.wr && (bus.idx == 3'(g));

			// A write landing with the transfer stays pending for the next one
			always_ff @(posedge i_clk) begin
				if (i_rst) begin
					bus.pend[g] <= 1'b0;
				end else if (hit) begin
					bus.pend[g] <= 1'b1;
				end else if (bus.xfer) begin
					bus.pend[g] <= 1'b0;
				end
			end

			// Data held in a register so the chain reads a stable byte
			always_ff @(posedge i_clk) begin
				if (i_rst) begin
					bus.data[g] <= 8'h00;
				end else if (hit) begin
					bus.data[g] <= bus.wdata;
				end
			end
		end
	endgenerate
endmodule

// File: hdl/rtc_calendar_count_chain.sv
// Calendar counting chain: BCD seconds to month with buffered software writes
`timescale 1ns/1ps
`include "rtc_cal_params.svh"
module rtc_calendar_count_chain
	import rtc_cal_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_subsec_ovf,
	input wire logic i_leap_year,
	input wire logic i_wr,
	input wire logic i_rd,
	input wire logic [2:0] i_addr,
	input wire logic [7:0] i_wdata,
	output logic [7:0] o_rdata,
	output logic o_rd_valid,
	output logic o_count_tick
);
	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic logic [7:0] bcd2bin(input bcd_t v);
		bcd2bin = 8'(8'(v[7:4]) * 8'd10 + 8'(v[3:0]));
	endfunction

	function automatic bcd_t bin2bcd(input logic [7:0] b);
		bin2bcd = {4'(b / 8'd10), 4'(b % 8'd10)};
	endfunction

	// Stored hour to 0..23; select bit 0 is the 12-hour system
	function automatic logic [7:0] hour_to24(input bcd_t h, input logic mode24);
		logic [7:0] hr;
		hr = bcd2bin({3'b000, h[4:0]});
		if (mode24) begin
			hour_to24 = bcd2bin(h);
		end else begin
			hour_to24 = 8'((hr == 8'd12) ? 8'd0 : hr) + (h[`CAL_HOUR_PM_BIT] ? 8'd12 : 8'd0);
		end
	endfunction

	// 0..23 to stored form; the afternoon flag adds 20 in BCD
	function automatic bcd_t hour_from24(input logic [7:0] b, input logic mode24);
		logic [7:0] hr;
		hr = b % 8'd12;
		if (hr == 8'd0) begin
			hr = 8'd12;
		end
		if (mode24) begin
			hour_from24 = bin2bcd(b);
		end else begin
			hour_from24 = bin2bcd(hr) | ((b >= 8'd12) ? 8'h20 : 8'h00);
		end
	endfunction

	// Days in the current month, BCD month in
	function automatic logic [7:0] month_len(input bcd_t mo, input logic leap);
		case (mo)
			8'h02: month_len = leap ? 8'd29 : 8'd28;
			8'h04, 8'h06, 8'h09, 8'h11: month_len = 8'd30;
			default: month_len = 8'd31;
		endcase
	endfunction

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	cal_wbuf_if wb ();
	logic [11:0] div_q;
	logic ce_q;
	logic leap_s1_q, leap_s2_q;
	logic sub_pend_q;
	logic hsel_q, hsel_d;
	bcd_t sec_q, min_q, hour_q, day_q, week_q, mon_q;
	bcd_t sec_d, min_d, hour_d, day_d, week_d, mon_d;
	logic sec_c, min_c, hour_c, day_c;
	logic day_inc;
	logic hsel_chg;
	logic [7:0] s_b, m_b, h24, d_b, w_b, mo_b, dmax;

	cal_write_buffer u_wbuf (
		.i_clk(i_clk),
		.i_rst(i_rst),
		.bus(wb.store)
	);

	// ----------------------------------------------------------------
	// Calendar count clock enable
	// ----------------------------------------------------------------
	// One-cycle pulse per count clock; the whole chain advances on it
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			div_q <= 12'h000;
			ce_q <= 1'b0;
		end else if (div_q == 12'(`CAL_CE_DIV - 1)) begin
			div_q <= 12'h000;
			ce_q <= 1'b1;
		end else begin
			div_q <= div_q + 12'h001;
			ce_q <= 1'b0;
		end
	end

	// Leap-year strap comes from a pin; two stages before use
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			leap_s1_q <= 1'b0;
			leap_s2_q <= 1'b0;
		end else begin
			leap_s1_q <= i_leap_year;
			leap_s2_q <= leap_s1_q;
		end
	end

	// Sub-second overflow held until the next count clock; a new one wins the clear
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			sub_pend_q <= 1'b0;
		end else if (i_subsec_ovf) begin
			sub_pend_q <= 1'b1;
		end else if (ce_q) begin
			sub_pend_q <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Register port: writes into the holding buffer, control direct
	// ----------------------------------------------------------------
	assign wb.wr = i_wr && (i_addr < 3'(`CAL_NUM_CNT));
	assign wb.idx = i_addr;
	assign wb.wdata = i_wdata;
	assign wb.xfer = ce_q;

	// Hour system select is taken at once, not through the buffer
	always_comb begin
		hsel_d = hsel_q;
		if (i_wr && (i_addr == `CAL_IDX_CTRL0)) begin
			hsel_d = i_wdata[`CAL_CTRL0_HSEL_BIT];
		end
	end
	assign hsel_chg = hsel_d != hsel_q;

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			hsel_q <= `CAL_RST_HSEL;
		end else begin
			hsel_q <= hsel_d;
		end
	end

	// ----------------------------------------------------------------
	// Counting chain, next values
	// ----------------------------------------------------------------
	// A pending write lands at the count clock and blocks the carry into it
	always_comb begin
		s_b = bcd2bin(sec_q);
		m_b = bcd2bin(min_q);
		h24 = hour_to24(hour_q, hsel_q);
		d_b = bcd2bin(day_q);
		w_b = bcd2bin(week_q);
		mo_b = bcd2bin(mon_q);
		dmax = month_len(mon_q, leap_s2_q);

		// Seconds
		sec_d = sec_q;
		sec_c = 1'b0;
		if (ce_q && wb.pend[`CAL_IDX_SEC]) begin
			sec_d = wb.data[`CAL_IDX_SEC];
		end else if (ce_q && sub_pend_q) begin
			sec_c = s_b >= `CAL_SEC_MAX;
			sec_d = sec_c ? 8'h00 : bin2bcd(s_b + 8'd1);
		end

		// Minutes
		min_d = min_q;
		min_c = 1'b0;
		if (ce_q && wb.pend[`CAL_IDX_MIN]) begin
			min_d = wb.data[`CAL_IDX_MIN];
		end else if (sec_c) begin
			min_c = m_b >= `CAL_MIN_MAX;
			min_d = min_c ? 8'h00 : bin2bcd(m_b + 8'd1);
		end

		// Hours, kept in the active system; re-encoded when the system changes
		hour_d = hour_q;
		hour_c = 1'b0;
		if (ce_q && wb.pend[`CAL_IDX_HOUR]) begin
			hour_d = wb.data[`CAL_IDX_HOUR];
		end else if (min_c) begin
			hour_c = h24 >= `CAL_HOUR24_MAX;
			hour_d = hour_from24(hour_c ? 8'd0 : h24 + 8'd1, hsel_d);
		end else if (hsel_chg) begin
			hour_d = hour_from24(h24, hsel_d);
		end

		// Day of month, length from month and leap year
		day_d = day_q;
		day_c = 1'b0;
		day_inc = 1'b0;
		if (ce_q && wb.pend[`CAL_IDX_DAY]) begin
			day_d = wb.data[`CAL_IDX_DAY];
		end else if (hour_c) begin
			day_inc = 1'b1;
			day_c = d_b >= dmax;
			day_d = day_c ? bin2bcd(`CAL_DAY_MIN) : bin2bcd(d_b + 8'd1);
		end

		// Weekday follows every day increment
		week_d = week_q;
		if (ce_q && wb.pend[`CAL_IDX_WEEK]) begin
			week_d = wb.data[`CAL_IDX_WEEK];
		end else if (day_inc) begin
			week_d = (w_b >= `CAL_WEEK_MAX) ? 8'h00 : bin2bcd(w_b + 8'd1);
		end

		// Month; its carry would feed a year count not kept here
		mon_d = mon_q;
		if (ce_q && wb.pend[`CAL_IDX_MONTH]) begin
			mon_d = wb.data[`CAL_IDX_MONTH];
		end else if (day_c) begin
			mon_d = (mo_b >= `CAL_MONTH_MAX) ? bin2bcd(`CAL_MONTH_MIN) : bin2bcd(mo_b + 8'd1);
		end
	end

	// ----------------------------------------------------------------
	// Counter registers
	// ----------------------------------------------------------------
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			sec_q <= `CAL_RST_SEC;
			min_q <= `CAL_RST_MIN;
			hour_q <= `CAL_RST_HOUR;
			day_q <= `CAL_RST_DAY;
			week_q <= `CAL_RST_WEEK;
			mon_q <= `CAL_RST_MONTH;
		end else begin
			sec_q <= sec_d;
			min_q <= min_d;
			hour_q <= hour_d;
			day_q <= day_d;
			week_q <= week_d;
			mon_q <= mon_d;
		end
	end

	// ----------------------------------------------------------------
	// Read port
	// ----------------------------------------------------------------
	// Reads show the live counters; a buffered write shows only once landed
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			o_rdata <= 8'h00;
			o_rd_valid <= 1'b0;
		end else begin
			o_rd_valid <= i_rd;
			if (i_rd) begin
				case (i_addr)
					`CAL_IDX_SEC: o_rdata <= sec_q;
					`CAL_IDX_MIN: o_rdata <= min_q;
					`CAL_IDX_HOUR: o_rdata <= hour_q;
					`CAL_IDX_DAY: o_rdata <= day_q;
					`CAL_IDX_WEEK: o_rdata <= week_q;
					`CAL_IDX_MONTH: o_rdata <= mon_q;
					`CAL_IDX_CTRL0: o_rdata <= 8'(hsel_q) << `CAL_CTRL0_HSEL_BIT;
					default: o_rdata <= 8'h00;
				endcase
			end
		end
	end

	// Count clock made visible for timing software writes
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			o_count_tick <= 1'b0;
		end else begin
			o_count_tick <= ce_q;
		end
	end
endmodule

// File: tb/rtc_cal_chk.sv
// Checker for the calendar chain register port and count tick
`timescale 1ns/1ps
`include "rtc_cal_params.svh"
module rtc_cal_chk (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_rd,
	input wire logic i_wr,
	input wire logic [2:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic [7:0] o_rdata,
	input wire logic o_rd_valid,
	input wire logic o_count_tick
);
	// ----------------------------------------
	// Tick spacing helper
	// ----------------------------------------
	logic [12:0] gap_q;
	logic seen_q;
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_rst);
	// Cycles since the last tick; cleared on each tick
	always_ff @(posedge i_clk) begin
		if (i_rst || o_count_tick) begin
			gap_q <= '0;
		end else begin
			gap_q <= gap_q + 13'h1;
		end
	end
	// The first tick after reset has no earlier tick to measure from
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			seen_q <= 1'b0;
		end else if (o_count_tick) begin
			seen_q <= 1'b1;
		end
	end
	// ----------------------------------------
	// Properties
	// ----------------------------------------
	sequence ctrl_wr_s;
		i_wr && i_addr == `CAL_IDX_CTRL0;
	endsequence
	sequence ctrl_rd_s;
		i_rd && i_addr == `CAL_IDX_CTRL0;
	endsequence
	rd_answer_a: assert property (i_rd |=> o_rd_valid)
		else $error("read not answered");
	rd_cause_a: assert property (o_rd_valid |-> $past(i_rd))
		else $error("read valid without read");
	rdata_hold_a: assert property (!o_rd_valid |-> $stable(o_rdata))
		else $error("read data moved without read");
	tick_pulse_a: assert property (o_count_tick |=> !o_count_tick)
		else $error("tick longer than one cycle");
	tick_period_a: assert property (o_count_tick && seen_q |-> gap_q == 13'(`CAL_CE_DIV - 1))
		else $error("count tick spacing wrong");
	hole_zero_a: assert property (i_rd && i_addr == 3'h7 |=> o_rdata == 8'h00)
		else $error("unmapped index not zero");
	ctrl_bits_a: assert property (ctrl_rd_s |=> (o_rdata & 8'hf7) == 8'h00)
		else $error("control spare bits set");
	ctrl_back_a: assert property (ctrl_wr_s ##2 ctrl_rd_s |=> o_rdata == ($past(i_wdata, 3) & 8'h08))
		else $error("control select not kept");
	sec_bcd_a: assert property (i_rd && i_addr == 3'h0 |=> o_rdata <= 8'h59 && o_rdata[3:0] <= 4'h9)
		else $error("seconds not BCD in range");
	week_range_a: assert property (i_rd && i_addr == 3'h4 |=> o_rdata <= 8'h06)
		else $error("weekday out of range");
endmodule

// File: tb/testbench.sv
// Self-checking bench for the calendar counting chain
`timescale 1ns/1ps
`include "rtc_cal_params.svh"
module testbench;
	logic i_clk = 1'b0;
	logic i_rst = 1'b1;
	logic i_subsec_ovf = 1'b0;
	logic i_leap_year = 1'b0;
	logic i_wr = 1'b0;
	logic i_rd = 1'b0;
	logic [2:0] i_addr = 3'h0;
	logic [7:0] i_wdata = 8'h00;
	logic [7:0] o_rdata;
	logic o_rd_valid;
	logic o_count_tick;
	int num_errors = 0;
	int checks = 0;
	int cycles = 0;
	// Per row: ctrl, leap, six setup values, write index and data, six results
	// Last row rolls a thirty-day month over into the next
	logic [127:0] tbl [9] = '{128'h00005959312806020700000012010003,
		128'h00005959111501050700000032150105, 128'h08015959232805020700000000290602,
		128'h08005959233103120700000000010401, 128'h08005959233103120110001023310312,
		128'h08005959233103120205000005310312, 128'h08005959233103120315000000150312,
		128'h08005959233103120507000000010407, 128'h08005959233002040700000000010305};
	logic [7:0] rv [8] = '{8'h00, 8'h00, 8'h12, 8'h01, 8'h00, 8'h01, 8'h00, 8'h00};
	rtc_calendar_count_chain rtc_calendar_count_chain_inst (.i_clk(i_clk), .i_rst(i_rst),
		.i_subsec_ovf(i_subsec_ovf), .i_leap_year(i_leap_year), .i_wr(i_wr), .i_rd(i_rd),
		.i_addr(i_addr), .i_wdata(i_wdata), .o_rdata(o_rdata), .o_rd_valid(o_rd_valid),
		.o_count_tick(o_count_tick));
	always #4 i_clk = ~i_clk;
	// ----------------------------------------
	// Port tasks
	// ----------------------------------------
	task automatic cmp(input logic [8:0] g, input logic [8:0] e);
		checks++;
		if (g !== e) begin
			num_errors++;
			$display("MISMATCH %0t got %h expected %h", $time, g, e);
		end
	endtask
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(negedge i_clk);
		i_wr = 1'b1;
		i_addr = a;
		i_wdata = d;
		@(negedge i_clk);
		i_wr = 1'b0;
	endtask
	// Expected 8'hff marks a value left unchecked
	task automatic rd(input logic [2:0] a, input logic [7:0] e);
		@(negedge i_clk);
		i_rd = 1'b1;
		i_addr = a;
		@(negedge i_clk);
		i_rd = 1'b0;
		if (e !== 8'hff) cmp({o_rd_valid, o_rdata}, {1'b1, e});
	endtask
	// Bounded by two count clocks so a missing count tick shows as a mismatch
	task automatic wait_tick();
		int n = 0;
		do begin
			@(negedge i_clk);
			n++;
		end while (o_count_tick !== 1'b1 && n < 2 * `CAL_CE_DIV + 4);
		cmp({8'h00, o_count_tick}, 9'h001);
	endtask
	task automatic wrap_up();
		if (num_errors == 0 && checks > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	// Cuts a hang short; the full run needs about 73000 cycles
	always @(posedge i_clk) begin
		cycles++;
		if (cycles == 90000) begin
			num_errors++;
			wrap_up();
		end
	end
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		repeat (4) @(negedge i_clk);
		i_rst = 1'b0;
		for (int k = 0; k < 8; k++) rd(3'(k), rv[k]);
		wr(3'h6, 8'h08);
		rd(3'h6, 8'h08);
		rd(3'h2, 8'h00);
		wr(3'h6, 8'h00);
		rd(3'h2, 8'h12);
		wr(3'h6, 8'hff);
		rd(3'h6, 8'h08);
		wr(3'h7, 8'h55);
		rd(3'h7, 8'h00);
		wait_tick();
		for (int r = 0; r < 9; r++) begin
			i_leap_year = tbl[r][112];
			wr(3'h6, tbl[r][127:120]);
			for (int k = 0; k < 6; k++) wr(3'(k), tbl[r][8 * (13 - k) +: 8]);
			wait_tick();
			for (int k = 0; k < 6; k++) rd(3'(k), tbl[r][8 * (13 - k) +: 8]);
			@(negedge i_clk);
			i_subsec_ovf = 1'b1;
			@(negedge i_clk);
			i_subsec_ovf = 1'b0;
			wr(tbl[r][58:56], tbl[r][55:48]);
			wait_tick();
			for (int k = 0; k < 6; k++) rd(3'(k), tbl[r][8 * (5 - k) +: 8]);
		end
		wrap_up();
	end
endmodule
bind rtc_calendar_count_chain rtc_cal_chk rtc_cal_chk_inst (.i_clk(i_clk), .i_rst(i_rst),
	.i_rd(i_rd), .i_wr(i_wr), .i_addr(i_addr), .i_wdata(i_wdata), .o_rdata(o_rdata),
	.o_rd_valid(o_rd_valid), .o_count_tick(o_count_tick));
